// File: hw/icpc_bank.v
// input clock priority and control register bank with avalon-mm slave
`timescale 1ns/1ns
`include "icpc_defines.vh"

module icpc_bank (
    // clock and reset
    input  wire         clk_sys,
    input  wire         nrst,
    // avalon-mm slave
    input  wire [7:0]   avs_address,
    input  wire         avs_read,
    input  wire         avs_write,
    input  wire [31:0]  avs_writedata,
    output reg  [31:0]  avs_readdata,
    output reg          avs_waitrequest,
    // rank outputs, four bits per input, input one lowest
    output reg  [35:0]  main_rank,
    output reg  [35:0]  sec_rank,
    output reg  [8:0]   main_ok,
    output reg  [8:0]   sec_ok,
    output reg  [3:0]   main_pick,
    output reg  [3:0]   sec_pick,
    // predivider and monitor configuration
    output reg  [8:0]   prog_div_on,
    output reg  [8:0]   fixed_div_on,
    output reg  [8:0]   alt_decode_on,
    output reg  [15:0]  divide_factor,
    output reg  [17:0]  bucket_sel,
    output reg  [161:0] loop_rate_khz
);

// ---------------------------------------------------------------
// storage
// ---------------------------------------------------------------
reg  [7:0] pm_r [0:4];
reg  [7:0] ps_r [0:4];
reg  [7:0] icr_r [0:8];
reg  [7:0] div_lo_r;
reg  [7:0] div_hi_r;
reg        net_std_r;
reg        bank_sel_r;

// ---------------------------------------------------------------
// bus decode
// ---------------------------------------------------------------
wire       req      = avs_read | avs_write;
wire       do_write = avs_write & ~avs_waitrequest;
wire       take_req = req & avs_waitrequest;
wire       load_rd  = avs_read & avs_waitrequest;
wire [7:0] wd       = avs_writedata[7:0];
wire       is_pri   = (avs_address >= `ICPC_IDX_PRI_12) &&
                      (avs_address <= `ICPC_IDX_PRI_9);
wire       is_ctrl  = (avs_address >= `ICPC_IDX_CTRL_FIRST) &&
                      (avs_address <= `ICPC_IDX_CTRL_LAST);
wire [2:0] pri_idx  = avs_address[2:0] - 3'h0;
wire [3:0] ctrl_idx = avs_address[3:0];

// ---------------------------------------------------------------
// functions
// ---------------------------------------------------------------
function [7:0] pri_mask;
    input [2:0] idx;
    begin
        case (idx)
            3'h3:    pri_mask = `ICPC_MASK_PRI_8;
            3'h4:    pri_mask = `ICPC_MASK_PRI_9;
            default: pri_mask = 8'hFF;
        endcase
    end
endfunction

// lowest nonzero rank wins; ties go to the lower input
function [3:0] best_input;
    input [35:0] ranks;
    integer k;
    reg [3:0] best;
    reg [3:0] win;
    begin
        best = 4'hF;
        win  = 4'h0;
        for (k = 8; k >= 0; k = k - 1) begin
            if (ranks[k*4 +: 4] != 4'h0 && ranks[k*4 +: 4] <= best) begin
                best = ranks[k*4 +: 4];
                win  = k[3:0] + 4'h1;
            end
        end
        best_input = win;
    end
endfunction

function [17:0] std_rate;
    input [3:0] code;
    input       sdh;
    begin
        case (code)
            4'h0:    std_rate = 18'h00008;
            4'h1:    std_rate = sdh ? 18'h00800 : 18'h00608;
            4'h2:    std_rate = 18'h01950;
            4'h3:    std_rate = 18'h04BF0;
            4'h4:    std_rate = 18'h06540;
            4'h5:    std_rate = 18'h097E0;
            4'h6:    std_rate = 18'h0CA80;
            4'h7:    std_rate = 18'h12FC0;
            4'h8:    std_rate = 18'h25F80;
            4'h9:    std_rate = 18'h00002;
            4'hA:    std_rate = 18'h00004;
            4'hB:    std_rate = 18'h018A8;
            4'hC:    std_rate = 18'h01388;
            4'hD:    std_rate = 18'h07A12;
            default: std_rate = 18'h00000;
        endcase
    end
endfunction

function [17:0] alt_rate;
    input [3:0] code;
    begin
        case (code)
            4'h0, 4'h1:       alt_rate = 18'h01388;
            4'h2, 4'h3, 4'h4: alt_rate = 18'h07A12;
            default:          alt_rate = 18'h00000;
        endcase
    end
endfunction

// ---------------------------------------------------------------
// packed rank views
// ---------------------------------------------------------------
wire [35:0] main_pack = {pm_r[4][3:0], pm_r[3][7:4], 4'h0, pm_r[2], pm_r[1], pm_r[0]};
wire [35:0] sec_pack  = {ps_r[4][3:0], ps_r[3][7:4], 4'h0, ps_r[2], ps_r[1], ps_r[0]};

// ---------------------------------------------------------------
// per-input mode and rate decode
// ---------------------------------------------------------------
wire [8:0]   pdiv_w;
wire [8:0]   fdiv_w;
wire [8:0]   alt_w;
wire [17:0]  bkt_w;
wire [161:0] rate_w;

genvar gi;
generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_in
        wire       pd   = icr_r[gi][`ICPC_BIT_PROG_DIV];
        wire       fd   = icr_r[gi][`ICPC_BIT_FIXED_DIV];
        wire [3:0] code = icr_r[gi][3:0];
        wire       lowk = (code == 4'h9) || (code == 4'hA);
        assign pdiv_w[gi] = pd & ~fd;
        assign fdiv_w[gi] = fd & ~pd & ~lowk;
        assign alt_w[gi]  = pd & fd;
        assign bkt_w[gi*2 +: 2] = icr_r[gi][5:4];
        assign rate_w[gi*18 +: 18] = alt_w[gi]  ? alt_rate(code) :
                                     fdiv_w[gi] ? 18'h00008 :
                                     std_rate(code, net_std_r);
    end
endgenerate

// ---------------------------------------------------------------
// registered outputs
// ---------------------------------------------------------------
integer j;
always @(posedge clk_sys) begin
    if (!nrst) begin
        main_rank     <= 36'h000000000;
        sec_rank      <= 36'h000000000;
        main_ok       <= 9'h000;
        sec_ok        <= 9'h000;
        main_pick     <= 4'h0;
        sec_pick      <= 4'h0;
        prog_div_on   <= 9'h000;
        fixed_div_on  <= 9'h000;
        alt_decode_on <= 9'h000;
        divide_factor <= 16'h0000;
        bucket_sel    <= 18'h00000;
        loop_rate_khz <= 162'h0;
    end else begin
        main_rank     <= main_pack;
        sec_rank      <= sec_pack;
        for (j = 0; j < 9; j = j + 1) begin
            main_ok[j] <= (main_pack[j*4 +: 4] != 4'h0);
            sec_ok[j]  <= (sec_pack[j*4 +: 4] != 4'h0);
        end
        main_pick     <= best_input(main_pack);
        sec_pick      <= best_input(sec_pack);
        prog_div_on   <= pdiv_w;
        fixed_div_on  <= fdiv_w;
        alt_decode_on <= alt_w;
        divide_factor <= {div_hi_r, div_lo_r};
        bucket_sel    <= bkt_w;
        loop_rate_khz <= rate_w;
    end
end

// ---------------------------------------------------------------
// register writes
// ---------------------------------------------------------------
// unused nibbles dropped on write
wire [7:0] pri_wd = wd & pri_mask(pri_idx);
integer n;
always @(posedge clk_sys) begin
    if (!nrst) begin
        pm_r[0]    <= `ICPC_RST_PRI_12;
        ps_r[0]    <= `ICPC_RST_PRI_12;
        pm_r[1]    <= `ICPC_RST_PRI_34;
        ps_r[1]    <= `ICPC_RST_PRI_34;
        pm_r[2]    <= `ICPC_RST_PRI_56;
        ps_r[2]    <= `ICPC_RST_PRI_56;
        pm_r[3]    <= `ICPC_RST_PRI_8_MAIN;
        ps_r[3]    <= `ICPC_RST_PRI_8_SEC;
        pm_r[4]    <= `ICPC_RST_PRI_9_MAIN;
        ps_r[4]    <= `ICPC_RST_PRI_9_SEC;
        for (n = 0; n < 9; n = n + 1) begin
            icr_r[n] <= (n < 4) ? `ICPC_RST_CTRL_LOW : `ICPC_RST_CTRL_HIGH;
        end
        div_lo_r   <= `ICPC_RST_DIV;
        div_hi_r   <= `ICPC_RST_DIV;
        net_std_r  <= 1'b0;
        bank_sel_r <= 1'b0;
    end else if (do_write) begin
        if (is_pri) begin
            if (bank_sel_r) begin
                ps_r[pri_idx] <= pri_wd;
            end else begin
                pm_r[pri_idx] <= pri_wd;
            end
        end else if (is_ctrl) begin
            icr_r[ctrl_idx] <= wd;
        end else begin
            case (avs_address)
                `ICPC_IDX_DIV_LOW:       div_lo_r   <= wd;
                `ICPC_IDX_DIV_HIGH:      div_hi_r   <= wd;
                `ICPC_IDX_MASTER_THREE:  net_std_r  <= wd[`ICPC_BIT_NET_STD];
                `ICPC_IDX_MASTER_ELEVEN: bank_sel_r <= wd[`ICPC_BIT_BANK_SEL];
                default: ;
            endcase
        end
    end
end

// ---------------------------------------------------------------
// read mux
// ---------------------------------------------------------------
reg [7:0] rd_nxt;
always @* begin
    rd_nxt = 8'h00;
    if (is_pri) begin
        rd_nxt = bank_sel_r ? ps_r[pri_idx] : pm_r[pri_idx];
    end else if (is_ctrl) begin
        rd_nxt = icr_r[ctrl_idx];
    end else begin
        case (avs_address)
            `ICPC_IDX_DIV_LOW:       rd_nxt = div_lo_r;
            `ICPC_IDX_DIV_HIGH:      rd_nxt = div_hi_r;
            `ICPC_IDX_MASTER_THREE:  rd_nxt = {5'h00, net_std_r, 2'h0};
            `ICPC_IDX_MASTER_ELEVEN: rd_nxt = {7'h00, bank_sel_r};
            default:                 rd_nxt = 8'h00;
        endcase
    end
end

// ---------------------------------------------------------------
// handshake: one wait cycle per request
// ---------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!nrst) begin
        avs_waitrequest <= 1'b1;
    end else begin
        avs_waitrequest <= ~take_req;
    end
end

// ---------------------------------------------------------------
// read data: loaded at first edge, taken at second
// ---------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!nrst) begin
        avs_readdata <= 32'h00000000;
    end else if (load_rd) begin
        avs_readdata <= {24'h000000, rd_nxt};
    end
end

endmodule // icpc_bank

// File: hw/icpc_defines.vh
// register map, reset values and field positions of the input clock priority bank
`ifndef ICPC_DEFINES_VH
`define ICPC_DEFINES_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define ICPC_IDX_PRI_12        8'h18
`define ICPC_IDX_PRI_34        8'h19
`define ICPC_IDX_PRI_56        8'h1A
`define ICPC_IDX_PRI_8         8'h1B
`define ICPC_IDX_PRI_9         8'h1C
`define ICPC_IDX_CTRL_FIRST    8'h20
`define ICPC_IDX_CTRL_LAST     8'h28
`define ICPC_IDX_DIV_LOW       8'h2A
`define ICPC_IDX_DIV_HIGH      8'h2B
`define ICPC_IDX_MASTER_THREE  8'h34
`define ICPC_IDX_MASTER_ELEVEN 8'h3C

// ---------------------------------------------------------------
// reset values, main bank then secondary bank
// ---------------------------------------------------------------
`define ICPC_RST_PRI_12        8'h10
`define ICPC_RST_PRI_34        8'h32
`define ICPC_RST_PRI_56        8'h00
`define ICPC_RST_PRI_8_MAIN    8'h40
`define ICPC_RST_PRI_8_SEC     8'h50
`define ICPC_RST_PRI_9_MAIN    8'h05
`define ICPC_RST_PRI_9_SEC     8'h00
`define ICPC_RST_CTRL_LOW      8'h00
`define ICPC_RST_CTRL_HIGH     8'h03
`define ICPC_RST_DIV           8'h00
`define ICPC_RST_MASTER        8'h00

// ---------------------------------------------------------------
// write masks and field positions
// ---------------------------------------------------------------
`define ICPC_MASK_PRI_8        8'hF0
`define ICPC_MASK_PRI_9        8'h0F
`define ICPC_BIT_PROG_DIV      7
`define ICPC_BIT_FIXED_DIV     6
`define ICPC_BIT_NET_STD       2
`define ICPC_BIT_BANK_SEL      0

`endif

// File: verif/icpc_monitor.sv
// assertion checker for the input clock priority bank
`timescale 1ns/1ns
module icpc_monitor (
    // clock and reset
    input wire         clk_sys,
    input wire         nrst,
    // register bus
    input wire         avs_read,
    input wire         avs_write,
    input wire [31:0]  avs_readdata,
    input wire         avs_waitrequest,
    // derived outputs
    input wire [35:0]  main_rank,
    input wire [8:0]   main_ok,
    input wire [3:0]   main_pick,
    input wire [8:0]   prog_div_on,
    input wire [8:0]   fixed_div_on,
    input wire [8:0]   alt_decode_on,
    input wire [161:0] loop_rate_khz
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("request not answered");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_ok_rank: assert property (main_ok[8] == (main_rank[35:32] != 4'h0))
        else $error("ok flag disagrees with rank");
    a_pick_valid: assert property (main_pick != 4'h0 |-> main_ok[main_pick - 4'h1])
        else $error("pick names excluded input");
    a_pick_none: assert property ((main_ok == 9'h0) == (main_pick == 4'h0))
        else $error("pick disagrees with ok flags");
    a_fixed_rate: assert property (fixed_div_on[0] |-> loop_rate_khz[17:0] == 18'h00008)
        else $error("fixed divide rate wrong");
    a_mode_excl: assert property (alt_decode_on[0] |->
        !fixed_div_on[0] && !prog_div_on[0])
        else $error("modes overlap");
    a_alt_rate: assert property (alt_decode_on[0] |->
        loop_rate_khz[17:0] inside {18'h01388, 18'h07A12, 18'h0})
        else $error("alternate rate wrong");
endmodule // icpc_monitor

bind icpc_bank icpc_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .main_rank(main_rank), .main_ok(main_ok), .main_pick(main_pick),
    .prog_div_on(prog_div_on), .fixed_div_on(fixed_div_on),
    .alt_decode_on(alt_decode_on), .loop_rate_khz(loop_rate_khz));

// File: verif/testbench.sv
// self-checking testbench for the input clock priority bank
`timescale 1ns/1ns
module testbench;
    logic         clk_sys, nrst, avs_read, avs_write;
    logic [7:0]   avs_address, rd;
    logic [31:0]  avs_writedata;
    wire  [31:0]  avs_readdata;
    wire          avs_waitrequest;
    wire  [35:0]  main_rank, sec_rank;
    wire  [8:0]   main_ok, sec_ok, prog_div_on, fixed_div_on, alt_decode_on;
    wire  [3:0]   main_pick, sec_pick;
    wire  [15:0]  divide_factor;
    wire  [17:0]  bucket_sel;
    wire  [161:0] loop_rate_khz;
    int           failures, tests_run;
    icpc_bank uut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .main_rank(main_rank), .sec_rank(sec_rank), .main_ok(main_ok), .sec_ok(sec_ok),
        .main_pick(main_pick), .sec_pick(sec_pick), .prog_div_on(prog_div_on),
        .fixed_div_on(fixed_div_on), .alt_decode_on(alt_decode_on),
        .divide_factor(divide_factor), .bucket_sel(bucket_sel), .loop_rate_khz(loop_rate_khz));
    // ------------------------------------------------------------
    // clock, bus tasks and checks
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    task chk(input [63:0] got, input [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task bus(input logic wr, input [7:0] a, input [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task rdchk(input [7:0] a, input [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        logic [7:0] m[5] = '{8'h10, 8'h32, 8'h00, 8'h40, 8'h05};
        logic [7:0] s[5] = '{8'h10, 8'h32, 8'h00, 8'h50, 8'h00};
        @(posedge clk_sys);
        chk({main_pick, sec_pick, loop_rate_khz[89:72]}, {8'h22, 18'h04BF0});
        for (int i = 0; i < 5; i++) rdchk(8'h18 + i, m[i]);
        bus(1'b1, 8'h3C, 8'h01);
        for (int i = 0; i < 5; i++) rdchk(8'h18 + i, s[i]);
        bus(1'b1, 8'h3C, 8'h00);
        rdchk(8'h20, 8'h00);
        rdchk(8'h24, 8'h03);
        $display("reset test done");
    endtask
    task t_bank;
        bus(1'b1, 8'h1A, 8'h21);
        bus(1'b1, 8'h3C, 8'h01);
        bus(1'b1, 8'h1A, 8'h43);
        bus(1'b1, 8'h1B, 8'hFF);
        bus(1'b1, 8'h1C, 8'hFF);
        rdchk(8'h1A, 8'h43);
        rdchk(8'h1B, 8'hF0);
        rdchk(8'h1C, 8'h0F);
        chk({main_rank[23:16], sec_rank[23:16]}, 16'h2143);
        bus(1'b1, 8'h7F, 8'hAA);
        rdchk(8'h7F, 8'h00);
        bus(1'b1, 8'h3C, 8'h00);
        rdchk(8'h1A, 8'h21);
        $display("bank test done");
    endtask
    task t_pick;
        bus(1'b1, 8'h18, 8'h00);
        bus(1'b1, 8'h19, 8'h00);
        bus(1'b1, 8'h1A, 8'h0F);
        bus(1'b1, 8'h1B, 8'h20);
        bus(1'b1, 8'h1C, 8'h01);
        @(posedge clk_sys);
        chk(main_pick, 4'h9);
        bus(1'b1, 8'h1C, 8'h00);
        @(posedge clk_sys);
        chk(main_pick, 4'h8);
        bus(1'b1, 8'h1B, 8'h00);
        @(posedge clk_sys);
        chk(main_pick, 4'h5);
        bus(1'b1, 8'h1A, 8'h00);
        @(posedge clk_sys);
        chk({main_ok, main_pick, sec_pick}, 17'h00002);
        chk(sec_ok, 9'h1BE);
        $display("pick test done");
    endtask
    task t_modes;
        logic [7:0]  c[10] = '{8'h05, 8'h83, 8'h43, 8'h49, 8'h4A, 8'hC0, 8'hC1,
                               8'hC3, 8'hC4, 8'hC5};
        logic [20:0] e[10] = '{21'h0097E0, 21'h104BF0, 21'h080008, 21'h000002, 21'h000004,
                               21'h041388, 21'h041388, 21'h047A12, 21'h047A12, 21'h040000};
        logic [17:0] r[16] = '{18'h00008, 18'h00608, 18'h01950, 18'h04BF0, 18'h06540,
                               18'h097E0, 18'h0CA80, 18'h12FC0, 18'h25F80, 18'h00002,
                               18'h00004, 18'h018A8, 18'h01388, 18'h07A12, 18'h0, 18'h0};
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 8'h20, c[i]);
            @(posedge clk_sys);
            chk({prog_div_on[0], fixed_div_on[0], alt_decode_on[0],
                 loop_rate_khz[17:0]}, e[i]);
        end
        for (int k = 0; k < 16; k++) begin
            bus(1'b1, 8'h20, 8'h30 | k[7:0]);
            @(posedge clk_sys);
            chk({bucket_sel[1:0], loop_rate_khz[17:0]}, {2'h3, r[k]});
        end
        bus(1'b1, 8'h34, 8'h04);
        bus(1'b1, 8'h20, 8'h01);
        bus(1'b1, 8'h2A, 8'h34);
        bus(1'b1, 8'h2B, 8'h12);
        @(posedge clk_sys);
        chk({divide_factor, loop_rate_khz[17:0]}, {16'h1234, 18'h00800});
        $display("mode test done");
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
        failures = 0;
        tests_run = 0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_bank;
        t_pick;
        t_modes;
        final_report;
    end
    initial begin
        #500000;
        failures++;
        final_report;
    end
endmodule // testbench
